// file: rec_ctrl_pkg.sv
package rec_ctrl_pkg;
	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 4'hC;
	// ==========================================================
	// command word bit positions
	localparam int CMD_RUN_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_DEFAULTS_BIT = 2;
	localparam int CMD_ARM_BIT = 3;
	localparam int CMD_SEGSIZE_BIT = 4;
	// config word bit positions
	localparam int CFG_GATE_BIT = 0;
	localparam int CFG_WRAP_BIT = 1;
	localparam int CFG_FIFO_BIT = 2;
	// status word bit positions
	localparam int ST_RUN_BIT = 0;
	localparam int ST_LEVEL_BIT = 16;
	localparam int ST_ACTIVE_BIT = 17;
	localparam int ST_WRAP_BIT = 18;
	localparam int ST_FIFO_BIT = 19;
	localparam int ST_FULL_BIT = 20;
	// ==========================================================
	// command results
	localparam logic [1:0] RES_OK = 2'h0;
	localparam logic [1:0] RES_REJECTED = 2'h1;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [15:0] RUN_STOPPED = 16'h0000;
	localparam logic [15:0] RUN_ACTIVE = 16'h0001;
	localparam int SEG_W = 16;
	localparam logic [SEG_W-1:0] SEG_DEFAULT = 16'h0010;
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;
	typedef struct packed
	{
		logic gate_active;
		logic wrap_select;
		logic fifo_mode;
	} settings_t;
	localparam settings_t SETTINGS_DEFAULT = '{gate_active: 1'b0, wrap_select: 1'b0,
		fifo_mode: 1'b0};
endpackage : rec_ctrl_pkg

// file: recording_acquire_control.sv
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - gate level is true when external input equals polarity switch
// - with gating active, exposures allowed only while gate level true
// - readable flag shows whether gating is active
// - wrap submode matters only in recorder storage mode, not FIFO
// - sequence submode stops recording when segment completely fills
// - ring submode wraps in segment, overwriting oldest images
// - ring submode ends on software stop or, with gating active, on gate level deassertion
// - submode reported as one flag: 0 sequence, 1 ring
// - in run state, triggers plus gate start exposures
// - stopped state halts exposures and puts sensor in idle
// - recording state overrides gate and trigger
// - run state entered only on software run command
// - stopped at reset, on stop command and defaults command
// - recording state read as 16-bit value: 0 stopped, 1 running
// - segment size change rejected while running
// - written settings take effect only on arm command
module recording_acquire_control
	import rec_ctrl_pkg::*;
#(
	parameter logic [SEG_W-1:0] SEG_SIZE_RESET = SEG_DEFAULT
)
(
	input wire logic MCLK_IN,
	input wire logic RESET_N_IN,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [DATA_W-1:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic ACQ_ENABLE_IN,
	input wire logic POLARITY_SWITCH_IN,
	input wire logic TRIGGER_IN,
	output logic EXPOSE_START_OUT,
	output logic SENSOR_IDLE_OUT,
	output logic WRITE_ADDR_OUT
);
	// ==========================================================
	// synchroniser and gate level
	logic acq_meta_reg, acq_sync_reg, acq_meta_next, acq_sync_next;
	logic acq_gate_level, gate_allows;
	always_comb
	begin
		acq_meta_next = ACQ_ENABLE_IN;
		acq_sync_next = acq_meta_reg;
	end
	always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			acq_meta_reg <= 1'b0;
			acq_sync_reg <= 1'b0;
		end
		else
		begin
			acq_meta_reg <= acq_meta_next;
			acq_sync_reg <= acq_sync_next;
		end
	end
	assign acq_gate_level = ~(acq_sync_reg ^ POLARITY_SWITCH_IN);
	// ==========================================================
	// bus slave, settings and recording state
	bus_state_t bus_reg, bus_next;
	settings_t staged_reg, staged_next, live_reg, live_next;
	logic run_reg, run_next, full_reg, full_next;
	logic [SEG_W-1:0] seg_size_reg, seg_size_next, wptr_reg, wptr_next;
	logic [1:0] result_reg, result_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic expose_reg, expose_next, idle_reg, idle_next;
	logic wr_hit, cmd_wr, cfg_wr, ring_mode, gate_off_stop, seg_end;
	logic acquire_ok;
	logic wait_reg, wait_next;
	// writes act at the edge that sees waitrequest low, as the master still holds them there
	assign wr_hit = (bus_reg == BUS_ANSWER) && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
	assign cmd_wr = wr_hit && (AVS_ADDRESS_IN == OFF_COMMAND);
	assign cfg_wr = wr_hit && (AVS_ADDRESS_IN == OFF_CONFIG);
	assign ring_mode = live_reg.wrap_select && !live_reg.fifo_mode;
	assign gate_allows = !live_reg.gate_active || acq_gate_level;
	assign gate_off_stop = ring_mode && live_reg.gate_active && !acq_gate_level;
	assign seg_end = (wptr_reg == seg_size_reg - 16'h0001);
	assign acquire_ok = run_reg && gate_allows && TRIGGER_IN;

	function automatic logic [DATA_W-1:0] status_word(input logic run, input logic lvl,
		input settings_t s, input logic full);
		logic [DATA_W-1:0] w;
		w = ZERO_WORD;
		w[15:0] = run ? RUN_ACTIVE : RUN_STOPPED;
		w[ST_LEVEL_BIT] = lvl;
		w[ST_ACTIVE_BIT] = s.gate_active;
		w[ST_WRAP_BIT] = s.wrap_select;
		w[ST_FIFO_BIT] = s.fifo_mode;
		w[ST_FULL_BIT] = full;
		return w;
	endfunction : status_word

	always_comb
	begin
		bus_next = bus_reg;
		staged_next = staged_reg;
		live_next = live_reg;
		run_next = run_reg;
		full_next = full_reg;
		seg_size_next = seg_size_reg;
		wptr_next = wptr_reg;
		result_next = result_reg;
		rdata_next = rdata_reg;
		expose_next = 1'b0;
		idle_next = !run_reg;
		wait_next = 1'b1;
		unique case (bus_reg)
			BUS_IDLE:
			begin
				if (AVS_READ_IN || AVS_WRITE_IN)
				begin
					bus_next = BUS_ANSWER;
					wait_next = 1'b0;
				end
				if (AVS_READ_IN)
				begin
					unique case (AVS_ADDRESS_IN)
						OFF_CONFIG: rdata_next = {29'h0000_0000, staged_reg.fifo_mode,
							staged_reg.wrap_select, staged_reg.gate_active};
						OFF_STATUS: rdata_next = status_word(run_reg, acq_gate_level,
							live_reg, full_reg);
						OFF_RESULT: rdata_next = {30'h0000_0000, result_reg};
						default: rdata_next = ZERO_WORD;
					endcase
				end
			end
			BUS_ANSWER:
				bus_next = BUS_IDLE;
			default:
				bus_next = BUS_IDLE;
		endcase
		if (cfg_wr)
		begin
			staged_next.gate_active = AVS_WRITEDATA_IN[CFG_GATE_BIT];
			staged_next.wrap_select = AVS_WRITEDATA_IN[CFG_WRAP_BIT];
			staged_next.fifo_mode = AVS_WRITEDATA_IN[CFG_FIFO_BIT];
		end
		// exposure and write pointer advance
		if (acquire_ok)
		begin
			expose_next = 1'b1;
			if (seg_end)
			begin
				wptr_next = '0;
				full_next = 1'b1;
				if (!ring_mode && !live_reg.fifo_mode)
					run_next = 1'b0;
			end
			else
				wptr_next = wptr_reg + 16'h0001;
		end
		if (gate_off_stop)
			run_next = 1'b0;
		if (cmd_wr)
		begin
			result_next = RES_OK;
			if (AVS_WRITEDATA_IN[CMD_ARM_BIT])
			begin
				live_next = staged_reg;
				wptr_next = '0;
				// a fill in the same cycle wins over the clear
				full_next = acquire_ok && seg_end;
			end
			if (AVS_WRITEDATA_IN[CMD_SEGSIZE_BIT])
			begin
				if (run_reg)
					result_next = RES_REJECTED;
				else
				begin
					seg_size_next = (AVS_WRITEDATA_IN[31:16] == 16'h0000) ? 16'h0001 :
						AVS_WRITEDATA_IN[31:16];
					wptr_next = '0;
					full_next = acquire_ok && seg_end;
				end
			end
			if (AVS_WRITEDATA_IN[CMD_RUN_BIT])
				run_next = 1'b1;
			if (AVS_WRITEDATA_IN[CMD_STOP_BIT])
				run_next = 1'b0;
			if (AVS_WRITEDATA_IN[CMD_DEFAULTS_BIT])
			begin
				run_next = 1'b0;
				staged_next = SETTINGS_DEFAULT;
				live_next = SETTINGS_DEFAULT;
			end
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			bus_reg <= BUS_IDLE;
			staged_reg <= SETTINGS_DEFAULT;
			live_reg <= SETTINGS_DEFAULT;
			run_reg <= 1'b0;
			full_reg <= 1'b0;
			seg_size_reg <= SEG_SIZE_RESET;
			wptr_reg <= '0;
			result_reg <= RES_OK;
			rdata_reg <= ZERO_WORD;
			expose_reg <= 1'b0;
			idle_reg <= 1'b1;
			wait_reg <= 1'b1;
		end
		else
		begin
			bus_reg <= bus_next;
			staged_reg <= staged_next;
			live_reg <= live_next;
			run_reg <= run_next;
			full_reg <= full_next;
			seg_size_reg <= seg_size_next;
			wptr_reg <= wptr_next;
			result_reg <= result_next;
			rdata_reg <= rdata_next;
			expose_reg <= expose_next;
			idle_reg <= idle_next;
			wait_reg <= wait_next;
		end
	end
	// waitrequest is low only in the answer cycle
	assign AVS_WAITREQUEST_OUT = wait_reg;
	assign AVS_READDATA_OUT = rdata_reg;
	assign EXPOSE_START_OUT = expose_reg;
	assign SENSOR_IDLE_OUT = idle_reg;
	assign WRITE_ADDR_OUT = full_reg;

	// ==========================================================
	// checks
	sequence run_cmd_s;
		cmd_wr && AVS_WRITEDATA_IN[CMD_RUN_BIT] && !AVS_WRITEDATA_IN[CMD_STOP_BIT]
			&& !AVS_WRITEDATA_IN[CMD_DEFAULTS_BIT];
	endsequence
	sequence bus_take_s;
		bus_reg == BUS_IDLE && (AVS_READ_IN || AVS_WRITE_IN);
	endsequence
	wait_pulse_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		bus_take_s |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
		else $error("waitrequest not low for exactly one cycle");
	gate_level_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		acq_gate_level == (acq_sync_reg == POLARITY_SWITCH_IN))
		else $error("gate level wrong");
	gate_block_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		live_reg.gate_active && !acq_gate_level |=> !EXPOSE_START_OUT)
		else $error("exposure while gate closed");
	stop_block_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		!run_reg |=> !EXPOSE_START_OUT && SENSOR_IDLE_OUT)
		else $error("exposure while stopped");
	defaults_stop_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		cmd_wr && AVS_WRITEDATA_IN[CMD_DEFAULTS_BIT] |=> !run_reg
			&& live_reg == SETTINGS_DEFAULT && staged_reg == SETTINGS_DEFAULT)
		else $error("defaults command did not stop recording");
	run_only_cmd_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		$rose(run_reg) |-> $past(cmd_wr && AVS_WRITEDATA_IN[CMD_RUN_BIT]))
		else $error("run without command");
	run_cmd_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		run_cmd_s |=> run_reg ##1 !SENSOR_IDLE_OUT)
		else $error("run command ignored");
	seq_stop_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		acquire_ok && seg_end && !ring_mode && !live_reg.fifo_mode && !cmd_wr |=> !run_reg)
		else $error("sequence did not stop");
	ring_wrap_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		acquire_ok && seg_end && ring_mode && !cmd_wr && !gate_off_stop |=> run_reg
			&& wptr_reg == 16'h0000)
		else $error("ring did not wrap");
	gate_stop_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		gate_off_stop |=> !run_reg)
		else $error("gate drop did not stop");
	seg_reject_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		cmd_wr && run_reg && AVS_WRITEDATA_IN[CMD_SEGSIZE_BIT] |=> $stable(seg_size_reg)
			&& result_reg == RES_REJECTED)
		else $error("segment change accepted while running");
	arm_apply_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		!(cmd_wr && (AVS_WRITEDATA_IN[CMD_ARM_BIT] || AVS_WRITEDATA_IN[CMD_DEFAULTS_BIT]))
			|=> $stable(live_reg))
		else $error("settings changed without arm");
	stop_cmd_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		cmd_wr && AVS_WRITEDATA_IN[CMD_STOP_BIT] |=> !run_reg)
		else $error("stop command ignored");
	idle_run_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		run_reg |=> !SENSOR_IDLE_OUT)
		else $error("sensor idle while running");
	expose_allow_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		run_reg && TRIGGER_IN && (!live_reg.gate_active || acq_gate_level) |=> EXPOSE_START_OUT)
		else $error("allowed trigger gave no exposure");
	fifo_keep_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		live_reg.fifo_mode && run_reg && !cmd_wr |=> run_reg)
		else $error("fifo storage stopped by itself");
	sync_delay_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		$past(RESET_N_IN, 2) |-> acq_sync_reg == $past(ACQ_ENABLE_IN, 2))
		else $error("gate input not two stages late");
	status_read_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		bus_take_s ##0 AVS_READ_IN && AVS_ADDRESS_IN == OFF_STATUS |=>
			AVS_READDATA_OUT[15:0] == {15'h0000, $past(run_reg)}
			&& AVS_READDATA_OUT[ST_WRAP_BIT] == $past(live_reg.wrap_select)
			&& AVS_READDATA_OUT[ST_ACTIVE_BIT] == $past(live_reg.gate_active))
		else $error("status word wrong");
	full_set_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
		acquire_ok && seg_end |=> WRITE_ADDR_OUT)
		else $error("segment end did not set filled flag");
endmodule : recording_acquire_control

// file: acq_source_model.sv
`timescale 1ns/1ps
module acq_source_model
(
	input wire logic clk_in,
	input wire logic level_in,
	input wire logic pol_in,
	output logic acq_out,
	output logic pol_out
);
	// ==========================================================
	// power unit: drives the acquire line so the requested gate level results
	initial
	begin
		acq_out = 1'b1;
		pol_out = 1'b1;
	end
	always @(posedge clk_in)
	begin
		acq_out <= level_in ~^ pol_in;
		pol_out <= pol_in;
	end
endmodule : acq_source_model

// file: recording_acquire_control_test.sv
`timescale 1ns/1ps
module recording_acquire_control_test;
	import rec_ctrl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wd = ZERO_WORD;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] q;
	logic wq, trig = 1'b0, lvl = 1'b1, pol = 1'b1, acq, pols, expose, idle, full;
	int n_mismatch = 0;
	int checks_done = 0;
	recording_acquire_control #(.SEG_SIZE_RESET(16'h0004)) dut (.MCLK_IN(clk), .RESET_N_IN(rst_n),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
		.AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq),
		.ACQ_ENABLE_IN(acq), .POLARITY_SWITCH_IN(pols), .TRIGGER_IN(trig),
		.EXPOSE_START_OUT(expose), .SENSOR_IDLE_OUT(idle), .WRITE_ADDR_OUT(full));
	acq_source_model far (.clk_in(clk), .level_in(lvl), .pol_in(pol), .acq_out(acq),
		.pol_out(pols));
	always #5 clk = ~clk;
	// ==========================================================
	// bus and compare tasks
	task check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %0s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task rdc(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		bus(1'b0, a, ZERO_WORD);
		check(what, q, exp);
	endtask : rdc
	task cmd(input int bitpos);
		bus(1'b1, OFF_COMMAND, ZERO_WORD | (32'h1 << bitpos));
	endtask : cmd
	task trg(input int n, input int exp);
		int seen;
		seen = 0;
		@(posedge clk);
		trig <= 1'b1;
		for (int i = 0; i < n + 2; i++)
		begin
			@(posedge clk);
			if (i == n - 1)
				trig <= 1'b0;
			if (expose === 1'b1)
				seen++;
		end
		check("expose", seen, exp);
	endtask : trg
	function automatic logic [DATA_W-1:0] st(logic r, logic l, logic a, logic w, logic f, logic u);
		logic [DATA_W-1:0] v;
		v = ZERO_WORD;
		v[ST_RUN_BIT] = r;
		v[ST_LEVEL_BIT] = l;
		v[ST_ACTIVE_BIT] = a;
		v[ST_WRAP_BIT] = w;
		v[ST_FIFO_BIT] = f;
		v[ST_FULL_BIT] = u;
		return v;
	endfunction : st
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
	// ==========================================================
	// tests
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		check("waitrequest", {31'h0, wq}, 32'h1);
		check("idle", {31'h0, idle}, 32'h1);
		repeat (3) @(posedge clk);
		rdc("status", OFF_STATUS, st(0, 1, 0, 0, 0, 0));
		check("idle", {31'h0, idle}, 32'h1);
		rdc("command", OFF_COMMAND, ZERO_WORD);
		rdc("unmapped", 4'h2, ZERO_WORD);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			lvl <= i[1];
			pol <= i[0];
			repeat (4) @(posedge clk);
			rdc("level", OFF_STATUS, st(0, i[1], 0, 0, 0, 0));
		end
		lvl <= 1'b1;
		$display("test level done");
		trg(1, 1'b0);
		cmd(CMD_RUN_BIT);
		rdc("status", OFF_STATUS, st(1, 1, 0, 0, 0, 0));
		check("idle", {31'h0, idle}, 32'h0);
		trg(1, 1'b1);
		$display("test run done");
		bus(1'b1, OFF_CONFIG, 32'h1);
		rdc("status", OFF_STATUS, st(1, 1, 0, 0, 0, 0));
		cmd(CMD_ARM_BIT);
		rdc("status", OFF_STATUS, st(1, 1, 1, 0, 0, 0));
		lvl <= 1'b0;
		repeat (4) @(posedge clk);
		trg(1, 1'b0);
		lvl <= 1'b1;
		repeat (4) @(posedge clk);
		trg(1, 1'b1);
		$display("test gate done");
		bus(1'b1, OFF_COMMAND, 32'h0004_0010);
		rdc("result", OFF_RESULT, {30'h0, RES_REJECTED});
		trg(10, 3);
		rdc("status", OFF_STATUS, st(0, 1, 1, 0, 0, 1));
		check("full", {31'h0, full}, 32'h1);
		check("idle", {31'h0, idle}, 32'h1);
		bus(1'b1, OFF_COMMAND, 32'h0004_0010);
		rdc("result", OFF_RESULT, {30'h0, RES_OK});
		$display("test sequence done");
		bus(1'b1, OFF_CONFIG, 32'h3);
		cmd(CMD_ARM_BIT);
		cmd(CMD_RUN_BIT);
		trg(10, 10);
		rdc("status", OFF_STATUS, st(1, 1, 1, 1, 0, 1));
		lvl <= 1'b0;
		repeat (4) @(posedge clk);
		rdc("status", OFF_STATUS, st(0, 0, 1, 1, 0, 1));
		lvl <= 1'b1;
		$display("test ring done");
		bus(1'b1, OFF_CONFIG, 32'h7);
		cmd(CMD_ARM_BIT);
		cmd(CMD_RUN_BIT);
		trg(10, 10);
		rdc("run", OFF_STATUS, st(1, 1, 1, 1, 1, 1));
		lvl <= 1'b0;
		repeat (4) @(posedge clk);
		rdc("fifo", OFF_STATUS, st(1, 0, 1, 1, 1, 1));
		lvl <= 1'b1;
		repeat (4) @(posedge clk);
		cmd(CMD_STOP_BIT);
		rdc("status", OFF_STATUS, st(0, 1, 1, 1, 1, 1));
		$display("test fifo done");
		cmd(CMD_RUN_BIT);
		cmd(CMD_DEFAULTS_BIT);
		rdc("status", OFF_STATUS, st(0, 1, 0, 0, 0, 1));
		rdc("config", OFF_CONFIG, ZERO_WORD);
		$display("test defaults done");
		wrap_up();
	end
endmodule : recording_acquire_control_test
